// ===== verilog/csfr_pkg.sv
// Package with register offsets, bit positions and reset values of the codec status flags.
package csfr_pkg;
    // ==========================================
    // Register offsets
    localparam logic [7:0] CSFR_OFS_MODULE_POWER_STATUS = 8'h5e;
    localparam logic [7:0] CSFR_OFS_DRIVER_SHORT_STATUS = 8'h5f;
    localparam logic [7:0] CSFR_OFS_LATCHED_FLAGS       = 8'h60;
    localparam logic [7:0] CSFR_OFS_LIVE_FLAGS          = 8'h61;
    localparam logic [7:0] CSFR_OFS_RESERVED_FIRST      = 8'h62;
    localparam logic [7:0] CSFR_OFS_RESERVED_LAST       = 8'h64;
    localparam logic [7:0] CSFR_OFS_CORE_CLOCK_SELECT   = 8'h65;
    // ==========================================
    // Module power status bit positions
    localparam int CSFR_PWR_LEFT_DAC   = 7;
    localparam int CSFR_PWR_RIGHT_DAC  = 6;
    localparam int CSFR_PWR_LEFT_LINE  = 4;
    localparam int CSFR_PWR_RIGHT_LINE = 3;
    localparam int CSFR_PWR_LEFT_HP    = 2;
    localparam int CSFR_PWR_RIGHT_HP   = 1;
    // ==========================================
    // Short status and flag bit positions
    localparam int CSFR_SHORT_MSB      = 7;
    localparam int CSFR_SHORT_LSB      = 4;
    localparam int CSFR_COM_PWR_LEFT   = 3;
    localparam int CSFR_COM_PWR_RIGHT  = 2;
    localparam int CSFR_FLAG_HEADSET   = 2;
    localparam int CSFR_FLAG_GATE_L    = 1;
    localparam int CSFR_FLAG_GATE_R    = 0;
    localparam int CSFR_CLK_SEL_BIT    = 0;
    // ==========================================
    // Widths and reset values
    localparam int         CSFR_DATA_W   = 8;
    localparam int         CSFR_NUM_COND = 7;
    localparam logic [7:0] CSFR_ZERO     = 8'h00;
    localparam logic       CSFR_CLK_SEL_RESET = 1'b0;
    localparam logic       CSFR_CLK_SEL_PLL   = 1'b0;
    localparam logic       CSFR_CLK_SEL_DIV   = 1'b1;
endpackage

// ===== verilog/csfr_sync3.sv
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module csfr_sync3
    import csfr_pkg::*;
#(
    parameter bit RESET_VAL = 1'b0
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);
    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       out_q;
    logic       out_d;

    always_comb begin
        stage_d = {stage_q[1:0], async_in};
        out_d   = (stage_q[1] == stage_q[2]) ? stage_q[2] : out_q;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            stage_q <= {3{RESET_VAL}};
            out_q   <= RESET_VAL;
        end else begin
            stage_q <= stage_d;
            out_q   <= out_d;
        end
    end

    assign sync_out = out_q;
endmodule

// ===== verilog/csfr_sticky_bit.sv
// One sticky flag bit: set by a condition, cleared by a read, set wins over clear.
`timescale 1ns/100ps
module csfr_sticky_bit (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic cond,
    input  wire logic clear,
    output logic      flag
);
    logic flag_q;
    logic flag_d;

    // A condition present in the clearing cycle keeps the bit set, so no event is lost.
    always_comb begin
        flag_d = cond | (flag_q & ~clear);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag = flag_q;
endmodule

// ===== verilog/csfr_regs.sv
// Status, flag and clock select registers of the codec control bank.
// ==========================================
// Summary of operation
// - Power status bit 7 is high only when the left DAC is fully up.
// - Power status bit 6 is high only when the right DAC is fully up.
// - Power status bit 4 follows the left line output driver power state.
// - Power status bit 3 is high only when the right line driver is fully up.
// - Power status bits 2 and 1 show left and right headphone drivers fully up.
// - Short status bits 7 to 4 show shorts on the four headphone drivers.
// - Short status bits 3 and 2 show both common drivers fully up.
// - Latched flags hold short detection in bits 7 to 4 after it clears.
// - Bit 2 of latched and live flags shows headset insertion or removal.
// - Latched bits 1 and 0 record left and right signal below noise gate.
// - Live flags share the latched layout and show present state unlatched.
// - Live bits 1 and 0 are high while each ADC is below noise gate.
// - The three reserved registers read zero; the host does not write them.
// - Clock register bit 0 picks the core clock source, resetting to zero.
`timescale 1ns/100ps
module csfr_regs
    import csfr_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   srst,
    // Register access port.
    input  wire logic [7:0]             reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [CSFR_DATA_W-1:0] reg_wdata,
    output logic      [CSFR_DATA_W-1:0] reg_rdata,
    output logic                        reg_rvalid,
    // Power-up indications from the analog modules.
    input  wire logic                   left_dac_up,
    input  wire logic                   right_dac_up,
    input  wire logic                   left_line_out_driver_up,
    input  wire logic                   right_line_out_driver_up,
    input  wire logic                   left_headphone_driver_up,
    input  wire logic                   right_headphone_driver_up,
    input  wire logic                   left_headphone_common_driver_up,
    input  wire logic                   right_headphone_common_driver_up,
    // Analog detector conditions.
    input  wire logic                   left_headphone_driver_short,
    input  wire logic                   right_headphone_driver_short,
    input  wire logic                   left_headphone_common_driver_short,
    input  wire logic                   right_headphone_common_driver_short,
    input  wire logic                   headset_change,
    input  wire logic                   left_adc_below_gate,
    input  wire logic                   right_adc_below_gate,
    // Core clock source choice.
    output logic                        codec_core_clock_in_sel
);
    // ==========================================
    // Input synchronisation
    logic left_dac_up_s;
    logic right_dac_up_s;
    logic left_line_up_s;
    logic right_line_up_s;
    logic left_hp_up_s;
    logic right_hp_up_s;
    logic left_com_up_s;
    logic right_com_up_s;
    logic left_hp_short_s;
    logic right_hp_short_s;
    logic left_com_short_s;
    logic right_com_short_s;
    logic headset_s;
    logic left_gate_s;
    logic right_gate_s;

    // Every analog level crosses into the register clock before any flag sees it.
    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_dac (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_dac_up),
        .sync_out (left_dac_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_dac (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_dac_up),
        .sync_out (right_dac_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_line (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_line_out_driver_up),
        .sync_out (left_line_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_line (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_line_out_driver_up),
        .sync_out (right_line_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_hp (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_headphone_driver_up),
        .sync_out (left_hp_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_hp (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_headphone_driver_up),
        .sync_out (right_hp_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_com (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_headphone_common_driver_up),
        .sync_out (left_com_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_com (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_headphone_common_driver_up),
        .sync_out (right_com_up_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_hp_short (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_headphone_driver_short),
        .sync_out (left_hp_short_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_hp_short (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_headphone_driver_short),
        .sync_out (right_hp_short_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_com_short (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_headphone_common_driver_short),
        .sync_out (left_com_short_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_com_short (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_headphone_common_driver_short),
        .sync_out (right_com_short_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_headset (
        .clock    (clock),
        .srst     (srst),
        .async_in (headset_change),
        .sync_out (headset_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_left_gate (
        .clock    (clock),
        .srst     (srst),
        .async_in (left_adc_below_gate),
        .sync_out (left_gate_s)
    );

    csfr_sync3 #(
        .RESET_VAL (1'b0)
    ) u_sync_right_gate (
        .clock    (clock),
        .srst     (srst),
        .async_in (right_adc_below_gate),
        .sync_out (right_gate_s)
    );

    // ==========================================
    // Status words
    logic [7:0] pwr_word;
    logic [7:0] short_word;
    logic [7:0] live_word;
    logic [3:0] short_live;
    logic       headset_live;
    logic [1:0] gate_live;

    assign short_live   = {left_hp_short_s, right_hp_short_s,
                           left_com_short_s, right_com_short_s};
    assign headset_live = headset_s;
    assign gate_live    = {left_gate_s, right_gate_s};

    always_comb begin
        pwr_word = CSFR_ZERO;
        pwr_word[CSFR_PWR_LEFT_DAC]   = left_dac_up_s;
        pwr_word[CSFR_PWR_RIGHT_DAC]  = right_dac_up_s;
        pwr_word[CSFR_PWR_LEFT_LINE]  = left_line_up_s;
        pwr_word[CSFR_PWR_RIGHT_LINE] = right_line_up_s;
        pwr_word[CSFR_PWR_LEFT_HP]    = left_hp_up_s;
        pwr_word[CSFR_PWR_RIGHT_HP]   = right_hp_up_s;
        short_word = CSFR_ZERO;
        short_word[CSFR_SHORT_MSB:CSFR_SHORT_LSB] = short_live;
        short_word[CSFR_COM_PWR_LEFT]  = left_com_up_s;
        short_word[CSFR_COM_PWR_RIGHT] = right_com_up_s;
        live_word = CSFR_ZERO;
        live_word[CSFR_SHORT_MSB:CSFR_SHORT_LSB] = short_live;
        live_word[CSFR_FLAG_HEADSET] = headset_live;
        live_word[CSFR_FLAG_GATE_L]  = gate_live[1];
        live_word[CSFR_FLAG_GATE_R]  = gate_live[0];
    end

    // ==========================================
    // Latched flags
    logic [CSFR_NUM_COND-1:0] sticky_cond;
    logic [CSFR_NUM_COND-1:0] sticky_flag;
    logic                     sticky_clear;
    logic [7:0]               sticky_word;

    assign sticky_cond  = {short_live, headset_live, gate_live};
    assign sticky_clear = reg_rd & (reg_addr == CSFR_OFS_LATCHED_FLAGS);

    for (genvar j = 0; j < CSFR_NUM_COND; j++) begin : g_sticky
        csfr_sticky_bit u_bit (
            .clock (clock),
            .srst  (srst),
            .cond  (sticky_cond[j]),
            .clear (sticky_clear),
            .flag  (sticky_flag[j])
        );
    end

    always_comb begin
        sticky_word = CSFR_ZERO;
        sticky_word[CSFR_SHORT_MSB:CSFR_SHORT_LSB] = sticky_flag[6:3];
        sticky_word[CSFR_FLAG_HEADSET] = sticky_flag[2];
        sticky_word[CSFR_FLAG_GATE_L]  = sticky_flag[1];
        sticky_word[CSFR_FLAG_GATE_R]  = sticky_flag[0];
    end

    // ==========================================
    // Clock select register
    logic clk_sel_q;
    logic clk_sel_d;

    // Only bit 0 is stored; the host keeps the upper bits zero, so they are dropped.
    always_comb begin
        clk_sel_d = clk_sel_q;
        if (reg_wr && reg_addr == CSFR_OFS_CORE_CLOCK_SELECT) begin
            clk_sel_d = reg_wdata[CSFR_CLK_SEL_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            clk_sel_q <= CSFR_CLK_SEL_RESET;
        end else begin
            clk_sel_q <= clk_sel_d;
        end
    end

    assign codec_core_clock_in_sel = clk_sel_q;

    // ==========================================
    // Read port
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;

    // The latched word is captured in the same cycle it is cleared, so a read loses nothing.
    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = reg_rd;
        if (reg_rd) begin
            unique case (reg_addr)
                CSFR_OFS_MODULE_POWER_STATUS: rdata_d = pwr_word;
                CSFR_OFS_DRIVER_SHORT_STATUS: rdata_d = short_word;
                CSFR_OFS_LATCHED_FLAGS:       rdata_d = sticky_word;
                CSFR_OFS_LIVE_FLAGS:          rdata_d = live_word;
                CSFR_OFS_CORE_CLOCK_SELECT: begin
                    rdata_d = CSFR_ZERO;
                    rdata_d[CSFR_CLK_SEL_BIT] = clk_sel_q;
                end
                default:                      rdata_d = CSFR_ZERO;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_q  <= CSFR_ZERO;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;
endmodule

// ===== dv/csfr_regs_assertions.sv
// Checker of the codec status flag register bank, seen at its ports.
`timescale 1ns/100ps
module csfr_regs_assertions (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic       left_dac_up,
    input wire logic       right_headphone_common_driver_short,
    input wire logic       headset_change,
    input wire logic       left_adc_below_gate,
    input wire logic       codec_core_clock_in_sel
);
    // ==========================================
    // Register read access and clock select writes
    default clocking @(posedge clock);
    endclocking
    default disable iff (srst);
    sequence s_rd(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    a_rvalid_pulse: assert property (reg_rvalid == $past(reg_rd))
        else $error("read valid not one cycle after the read strobe");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    a_reserved_zero: assert property (
        reg_rd && reg_addr inside {[8'h62:8'h64]} |=> reg_rdata == 8'h00)
        else $error("reserved register read nonzero");
    a_sel_write: assert property (
        reg_wr && reg_addr == 8'h65 |=> codec_core_clock_in_sel == $past(reg_wdata[0]))
        else $error("clock select did not take the written bit");
    a_sel_hold: assert property (
        !(reg_wr && reg_addr == 8'h65) |=> $stable(codec_core_clock_in_sel))
        else $error("clock select changed without a write");
    // ==========================================
    // Status and flags, with a margin for the synchroniser delay
    a_dac_power: assert property (
        left_dac_up[*8] ##0 s_rd(8'h5e) |=> reg_rdata[7])
        else $error("left converter power bit low");
    a_short_seen: assert property (
        right_headphone_common_driver_short[*8] ##0 s_rd(8'h5f) |=> reg_rdata[4])
        else $error("right common short bit low");
    a_live_gate: assert property (
        left_adc_below_gate[*8] ##0 s_rd(8'h61) |=> reg_rdata[1])
        else $error("left noise gate live bit low");
    a_latched_set: assert property (
        headset_change[*8] ##0 s_rd(8'h60) |=> reg_rdata[2])
        else $error("headset latched bit low");
endmodule

// ===== dv/csfr_host_model.sv
// Host model that drives the register port of the codec status bank.
`timescale 1ns/100ps
module csfr_host_model (
    input  wire logic       clock,
    output logic      [7:0] reg_addr = 8'h00,
    output logic            reg_wr = 1'b0,
    output logic            reg_rd = 1'b0,
    output logic      [7:0] reg_wdata = 8'h00,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    // ==========================================
    // Access tasks
    // Strobes are single-cycle pulses, so the address only needs to hold one edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a inside {[8'h5e:8'h64]}) return;
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_wdata = (a == 8'h65) ? {7'h00, d[0]} : d;
        reg_wr = 1'b1;
        @(posedge clock);
        #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clock);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clock);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
        v = reg_rvalid;
    endtask
endmodule

// ===== dv/codec_status_flag_regs_test.sv
// Self-checking bench of the codec status flag register bank.
`timescale 1ns/100ps
module codec_status_flag_regs_test;
    import csfr_pkg::*;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [14:0] st = 15'h0000;
    logic [7:0]  e;
    wire  [7:0]  reg_addr, reg_wdata, reg_rdata;
    wire         reg_wr, reg_rd, reg_rvalid, codec_core_clock_in_sel;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #5 clock = ~clock;
    csfr_host_model i_host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    csfr_regs i_dut (.clock, .srst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid, .codec_core_clock_in_sel,
        .left_dac_up(st[7]), .right_dac_up(st[6]), .left_line_out_driver_up(st[5]),
        .right_line_out_driver_up(st[4]), .left_headphone_driver_up(st[3]),
        .right_headphone_driver_up(st[2]), .left_headphone_common_driver_up(st[1]),
        .right_headphone_common_driver_up(st[0]), .left_headphone_driver_short(st[11]),
        .right_headphone_driver_short(st[10]), .left_headphone_common_driver_short(st[9]),
        .right_headphone_common_driver_short(st[8]), .headset_change(st[12]),
        .left_adc_below_gate(st[14]), .right_adc_below_gate(st[13]));
    // ==========================================
    // Expected words and checks
    function automatic logic [7:0] pwr(logic [14:0] s);
        return {s[7:6], 1'b0, s[5:2], 1'b0};
    endfunction
    function automatic logic [7:0] shr(logic [14:0] s);
        return {s[11:8], s[1:0], 2'b00};
    endfunction
    function automatic logic [7:0] live(logic [14:0] s);
        return {s[11:8], 1'b0, s[12], s[14:13]};
    endfunction
    task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", n, exp, seen);
        end
    endtask
    task automatic rchk(logic [7:0] a, logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_host.rd(a, d, v);
        check($sformatf("read of %h", a), d, exp);
        check("read valid", {7'h00, v}, 8'h01);
    endtask
    task automatic give_verdict;
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // A hang in the bench is cut short well past the expected run length.
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            give_verdict();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        #1 srst = 1'b0;
        for (int a = 'h5e; a <= 'h66; a++) rchk(8'(a), 8'h00);
        for (int b = 0; b < 15; b++) begin
            st = 15'(1) << b;
            repeat (6) @(posedge clock);
            rchk(8'h5e, pwr(st));
            rchk(8'h5f, shr(st));
            rchk(8'h61, live(st));
            rchk(8'h60, live(st));
            rchk(8'h60, live(st));
            e = live(st);
            st = 15'h0000;
            repeat (6) @(posedge clock);
            rchk(8'h61, 8'h00);
            rchk(8'h60, e);
            rchk(8'h60, 8'h00);
        end
        i_host.wr(8'h65, 8'h01);
        check("clock select", {7'h00, codec_core_clock_in_sel}, 8'h01);
        i_host.wr(8'h66, 8'h00);
        rchk(8'h65, 8'h01);
        srst = 1'b1;
        repeat (4) @(posedge clock);
        #1 srst = 1'b0;
        check("clock select", {7'h00, codec_core_clock_in_sel}, 8'h00);
        i_host.wr(8'h65, 8'h01);
        i_host.wr(8'h65, 8'h00);
        rchk(8'h65, 8'h00);
        give_verdict();
    end
endmodule
bind csfr_regs csfr_regs_assertions i_chk (.clock, .srst, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .reg_rvalid, .left_dac_up, .right_headphone_common_driver_short,
    .headset_change, .left_adc_below_gate, .codec_core_clock_in_sel);
